// file: tmx_pkg.sv
// Constants, types and helper functions shared by the instruction executor.
// What this block does
// - Register versus memory compare, skip on equal/greater-equal.
// - Memory versus immediate compare, skip, memory unchanged.
// - AND/OR immediate into memory, XOR into register.
// - Load memory into register, store register into memory.
// - Indirect moves use row plus register as column.
// - Memory-to-memory move within one row.
// - Immediate move writes nibble into memory.
// - Synthesizer load sends memory nibble to selected register.
// - Memory bit tests skip on all-ones or all-zeros.
// - Jump loads twelve-bit absolute address.
// - Call pushes return address, return pops it.
// - Timer or unlock flag test skips when zero.
// - Status set/reset forces masked status-one bits.
// - Status-two tests skip on all-ones or all-zeros.
// - Bank select chooses one of four banks.
// - Display writes memory nibble direct or seven-segment.
// - Port input to memory, port output from memory.
// - Port bit set/clear and port bit tests.
// - Counter-flag instructions load control words one/two.
// - Port F direction latch, set bit means output.
// - Clock stop halts only while hold is low.
// - Converter load writes immediate into converter register.
// - Port E follows last input or output instruction.
// - Hold mode needs hold low and enable flag.
package tmx_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATE = 8'h04;
   localparam logic [7:0] ADDR_STAT1 = 8'h08;
   localparam int CTRL_RUN_BIT = 0;
   localparam int STATE_STOP_BIT = 16;
   localparam int STATE_HOLD_BIT = 17;
   localparam int STATE_SKIP_BIT = 18;
   localparam int HOLD_ENABLE_FLAG_BIT = 0;
   localparam logic [11:0] PC_RST = 12'h000;
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [1:0] BANK_RST = 2'h0;
   localparam logic [3:0] PORT_A = 4'h0;
   localparam logic [3:0] PORT_B = 4'h1;
   localparam logic [3:0] PORT_C = 4'h2;
   localparam logic [3:0] PORT_E = 4'h3;
   localparam logic [3:0] PORT_F = 4'h4;
   localparam logic [3:0] PORT_G = 4'h5;
   localparam logic [3:0] PORT_H = 4'h6;
   localparam logic [5:0] OP_SEQ = 6'h01;
   localparam logic [5:0] OP_SGE = 6'h03;
   localparam logic [5:0] OP_SKIP_MEM_EQ_IMM = 6'h05;
   localparam logic [5:0] OP_SKIP_MEM_GE_IMM = 6'h07;
   localparam logic [5:0] OP_XOR = 6'h0a;
   localparam logic [5:0] OP_AND = 6'h0c;
   localparam logic [5:0] OP_OR = 6'h0e;
   localparam logic [5:0] OP_ST = 6'h21;
   localparam logic [5:0] OP_MOVE_TO_INDIRECT = 6'h22;
   localparam logic [5:0] OP_MOVE_FROM_INDIRECT = 6'h23;
   localparam logic [5:0] OP_LD = 6'h24;
   localparam logic [5:0] OP_MOVE_MEM_TO_MEM = 6'h25;
   localparam logic [5:0] OP_PLL = 6'h26;
   localparam logic [5:0] OP_MVI = 6'h27;
   localparam logic [5:0] OP_TMT = 6'h29;
   localparam logic [5:0] OP_TMF = 6'h2b;
   localparam logic [5:0] OP_DISPLAY_DIRECT_WRITE = 6'h38;
   localparam logic [5:0] OP_DISPLAY_SEGMENT_WRITE = 6'h39;
   localparam logic [5:0] OP_IN = 6'h3a;
   localparam logic [5:0] OP_OUT = 6'h3b;
   localparam logic [3:0] OP_JMP = 4'hb;
   localparam logic [3:0] OP_CAL = 4'hc;
   localparam logic [11:0] OP_TTM = 12'hdf0;
   localparam logic [11:0] OP_TUL = 12'hd78;
   localparam logic [11:0] OP_SS = 12'hdc0;
   localparam logic [11:0] OP_RS = 12'hdc4;
   localparam logic [11:0] OP_TST = 12'hdfc;
   localparam logic [11:0] OP_TSF = 12'hdc8;
   localparam logic [7:0] OP_SPB = 8'hf1;
   localparam logic [7:0] OP_RPB = 8'hf7;
   localparam logic [7:0] OP_TPT = 8'hfa;
   localparam logic [7:0] OP_TPF = 8'hff;
   localparam logic [11:0] OP_UCS = 12'h010;
   localparam logic [11:0] OP_UCC = 12'h030;
   localparam logic [11:0] OP_DAC = 12'h020;
   localparam logic [11:0] OP_FPC = 12'h100;
   localparam logic [15:0] OP_CLOCK_STOP = 16'h1100;
   localparam logic [15:0] OP_RT = 16'hd4fd;
   localparam logic [15:0] OP_NOP = 16'h0000;
   localparam logic [13:0] OP_BANK = 14'h3414;
   typedef struct packed {
      logic [5:0] op6;
      logic [1:0] dh;
      logic [3:0] dl;
      logic [3:0] lo;
   } tmx_instr_t;
   typedef struct packed {
      logic wr;
      logic [3:0] digit;
      logic [6:0] seg;
   } tmx_lcd_t;
   typedef struct packed {
      logic wr;
      logic [3:0] sel;
      logic [3:0] data;
   } tmx_pll_t;
   typedef enum logic [2:0] {
      CORE_IDLE = 3'b001,
      CORE_RUN = 3'b010,
      CORE_STOP = 3'b100
   } tmx_core_t;
   function automatic logic [6:0] seg7(input logic [3:0] v);
      logic [6:0] s;
      s = 7'h00;
      case (v)
         4'h0: s = 7'h3f;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5b;
         4'h3: s = 7'h4f;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6d;
         4'h6: s = 7'h7d;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h6f;
         4'ha: s = 7'h77;
         4'hb: s = 7'h7c;
         4'hc: s = 7'h39;
         4'hd: s = 7'h5e;
         4'he: s = 7'h79;
         default: s = 7'h71;
      endcase
      return s;
   endfunction
   // Masked test: true when every selected bit equals the wanted level.
   function automatic logic bits_all(input logic [3:0] v, input logic [3:0] m, input logic want);
      return want ? ((v & m) == m) : ((v & m) == 4'h0);
   endfunction
endpackage

// file: tmx_core.sv
// Instruction executor of the tuner controller with its APB control registers.
//
// Decided for this implementation: the address map and the APB slave port.
module tmx_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [11:0] rom_addr,
   input wire logic [15:0] rom_data,
   input wire logic hold_n,
   input wire logic timer_flag,
   input wire logic unlock_flag,
   input wire logic [3:0] status2,
   input wire logic [3:0] port_a_in,
   input wire logic [3:0] port_g_in,
   input wire logic [3:0] port_e_in,
   output logic [3:0] port_e_out,
   output logic [3:0] port_e_oe,
   input wire logic [3:0] port_f_in,
   output logic [3:0] port_f_out,
   output logic [3:0] port_f_oe,
   output logic [3:0] port_b_out,
   output logic [1:0] port_c_out,
   output logic [1:0] port_h_out,
   output tmx_pkg::tmx_lcd_t lcd,
   output tmx_pkg::tmx_pll_t pll,
   output logic [3:0] counter_control_word_one,
   output logic [3:0] counter_control_word_two,
   output logic [3:0] dac_data,
   output logic [3:0] status1,
   output logic [1:0] bank,
   output logic hold_mode,
   output logic stopped
);
   tmx_pkg::tmx_instr_t ins;
   tmx_pkg::tmx_core_t core_q;
   logic run_q, skip_q, skip_d, ex, e_dir_q;
   logic [11:0] pc_q, pc_d;
   logic [11:0] stk_q [4];
   logic [1:0] sp_q;
   logic push, pop;
   logic [3:0] ram_q [256];
   logic ram_we;
   logic [7:0] ram_wa, m_addr, r_addr, ind_addr, m2_addr;
   logic [3:0] ram_wd, m_val, r_val, ind_val, m2_val, pn, port_val, port_wd;
   logic port_we;
   logic [3:0] f_dir_q;
   logic [11:0] hi12;
   logic [7:0] hi8;

   assign ins = rom_data;
   assign hi12 = rom_data[15:4];
   assign hi8 = rom_data[15:8];
   assign rom_addr = pc_q;
   assign m_addr = {bank, ins.dh, ins.dl};
   assign r_addr = {bank, 2'b00, ins.lo};
   assign m2_addr = {bank, ins.dh, ins.lo};
   assign m_val = ram_q[m_addr];
   assign r_val = ram_q[r_addr];
   assign ind_addr = {bank, ins.dh, r_val};
   assign ind_val = ram_q[ind_addr];
   assign m2_val = ram_q[m2_addr];
   assign ex = (core_q == tmx_pkg::CORE_RUN) && !skip_q;
   assign stopped = (core_q == tmx_pkg::CORE_STOP);
   assign hold_mode = !hold_n && status1[tmx_pkg::HOLD_ENABLE_FLAG_BIT];
   assign port_e_oe = {4{e_dir_q}};
   assign port_f_oe = f_dir_q;

   // Port number sits in the low nibble for whole-port moves, else in the column field.
   always_comb begin
      pn = (ins.op6 == tmx_pkg::OP_IN || ins.op6 == tmx_pkg::OP_OUT) ? ins.lo : ins.dl;
      unique case (pn)
         tmx_pkg::PORT_A: port_val = port_a_in;
         tmx_pkg::PORT_B: port_val = port_b_out;
         tmx_pkg::PORT_C: port_val = {2'b00, port_c_out};
         tmx_pkg::PORT_E: port_val = e_dir_q ? port_e_out : port_e_in;
         tmx_pkg::PORT_F: port_val = (f_dir_q & port_f_out) | (~f_dir_q & port_f_in);
         tmx_pkg::PORT_G: port_val = port_g_in;
         tmx_pkg::PORT_H: port_val = {2'b00, port_h_out};
         default: port_val = 4'h0;
      endcase
   end

   // Decode and execute one instruction a cycle.
   always_comb begin
      skip_d = 1'b0;
      ram_we = 1'b0;
      ram_wa = m_addr;
      ram_wd = m_val;
      pc_d = pc_q + 12'h001;
      push = 1'b0;
      pop = 1'b0;
      port_we = 1'b0;
      port_wd = m_val;
      if (ex) begin
         if (ins.op6[5:2] == tmx_pkg::OP_JMP) begin
            pc_d = rom_data[11:0];
         end else if (ins.op6[5:2] == tmx_pkg::OP_CAL) begin
            pc_d = rom_data[11:0];
            push = 1'b1;
         end else if (rom_data == tmx_pkg::OP_RT) begin
            pc_d = stk_q[sp_q - 2'd1];
            pop = 1'b1;
         end
         unique case (ins.op6)
            tmx_pkg::OP_SEQ: skip_d = (r_val == m_val);
            tmx_pkg::OP_SGE: skip_d = (r_val >= m_val);
            tmx_pkg::OP_SKIP_MEM_EQ_IMM: skip_d = (m_val == ins.lo);
            tmx_pkg::OP_SKIP_MEM_GE_IMM: skip_d = (m_val >= ins.lo);
            tmx_pkg::OP_XOR: begin
               ram_we = 1'b1;
               ram_wa = r_addr;
               ram_wd = r_val ^ m_val;
            end
            tmx_pkg::OP_AND: begin
               ram_we = 1'b1;
               ram_wd = m_val & ins.lo;
            end
            tmx_pkg::OP_OR: begin
               ram_we = 1'b1;
               ram_wd = m_val | ins.lo;
            end
            tmx_pkg::OP_LD: begin
               ram_we = 1'b1;
               ram_wa = r_addr;
            end
            tmx_pkg::OP_ST: begin
               ram_we = 1'b1;
               ram_wd = r_val;
            end
            tmx_pkg::OP_MOVE_TO_INDIRECT: begin
               ram_we = 1'b1;
               ram_wa = ind_addr;
            end
            tmx_pkg::OP_MOVE_FROM_INDIRECT: begin
               ram_we = 1'b1;
               ram_wd = ind_val;
            end
            tmx_pkg::OP_MOVE_MEM_TO_MEM: begin
               ram_we = 1'b1;
               ram_wd = m2_val;
            end
            tmx_pkg::OP_MVI: begin
               ram_we = 1'b1;
               ram_wd = ins.lo;
            end
            tmx_pkg::OP_TMT: skip_d = tmx_pkg::bits_all(m_val, ins.lo, 1'b1);
            tmx_pkg::OP_TMF: skip_d = tmx_pkg::bits_all(m_val, ins.lo, 1'b0);
            tmx_pkg::OP_IN: begin
               ram_we = 1'b1;
               ram_wd = port_val;
            end
            tmx_pkg::OP_OUT: port_we = 1'b1;
            default: ;
         endcase
         unique case (hi12)
            tmx_pkg::OP_TTM: skip_d = !timer_flag;
            tmx_pkg::OP_TUL: skip_d = !unlock_flag;
            tmx_pkg::OP_TST: skip_d = tmx_pkg::bits_all(status2, ins.lo, 1'b1);
            tmx_pkg::OP_TSF: skip_d = tmx_pkg::bits_all(status2, ins.lo, 1'b0);
            default: ;
         endcase
         unique case (hi8)
            tmx_pkg::OP_SPB: begin
               port_we = 1'b1;
               port_wd = port_val | ins.lo;
            end
            tmx_pkg::OP_RPB: begin
               port_we = 1'b1;
               port_wd = port_val & ~ins.lo;
            end
            tmx_pkg::OP_TPT: skip_d = tmx_pkg::bits_all(port_val, ins.lo, 1'b1);
            tmx_pkg::OP_TPF: skip_d = tmx_pkg::bits_all(port_val, ins.lo, 1'b0);
            default: ;
         endcase
      end
   end

   // Memory keeps no reset value, as battery-backed data must survive a reset.
   always_ff @(posedge pclk) begin
      if (ram_we) begin
         ram_q[ram_wa] <= ram_wd;
      end
   end

   // Four-deep return stack; a fifth call overwrites the oldest entry.
   always_ff @(posedge pclk) begin
      if (push) begin
         stk_q[sp_q] <= pc_q + 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= tmx_pkg::PC_RST;
         sp_q <= 2'h0;
         skip_q <= 1'b0;
      end else if (core_q == tmx_pkg::CORE_RUN) begin
         pc_q <= pc_d;
         skip_q <= skip_d;
         if (push) begin
            sp_q <= sp_q + 2'd1;
         end else if (pop) begin
            sp_q <= sp_q - 2'd1;
         end
      end
   end

   // Stop only takes effect with hold low and ends as soon as hold rises.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_q <= tmx_pkg::CORE_IDLE;
      end else begin
         unique case (core_q)
            tmx_pkg::CORE_IDLE: if (run_q) core_q <= tmx_pkg::CORE_RUN;
            tmx_pkg::CORE_RUN: begin
               if (!run_q) begin
                  core_q <= tmx_pkg::CORE_IDLE;
               end else if (ex && rom_data == tmx_pkg::OP_CLOCK_STOP && !hold_n) begin
                  core_q <= tmx_pkg::CORE_STOP;
               end
            end
            tmx_pkg::CORE_STOP: if (hold_n) core_q <= tmx_pkg::CORE_RUN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status1 <= tmx_pkg::NIB_RST;
         bank <= tmx_pkg::BANK_RST;
         counter_control_word_one <= tmx_pkg::NIB_RST;
         counter_control_word_two <= tmx_pkg::NIB_RST;
         dac_data <= tmx_pkg::NIB_RST;
         f_dir_q <= tmx_pkg::NIB_RST;
      end else if (ex) begin
         if (hi12 == tmx_pkg::OP_SS) status1 <= status1 | ins.lo;
         if (hi12 == tmx_pkg::OP_RS) status1 <= status1 & ~ins.lo;
         if ({rom_data[15:10], rom_data[7:0]} == tmx_pkg::OP_BANK) bank <= rom_data[9:8];
         if (hi12 == tmx_pkg::OP_UCS) counter_control_word_one <= ins.lo;
         if (hi12 == tmx_pkg::OP_UCC) counter_control_word_two <= ins.lo;
         if (hi12 == tmx_pkg::OP_DAC) dac_data <= ins.lo;
         if (hi12 == tmx_pkg::OP_FPC) f_dir_q <= ins.lo;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd <= '0;
         pll <= '0;
      end else begin
         lcd.wr <= ex && (ins.op6 == tmx_pkg::OP_DISPLAY_DIRECT_WRITE || ins.op6 == tmx_pkg::OP_DISPLAY_SEGMENT_WRITE);
         lcd.digit <= ins.lo;
         lcd.seg <= (ins.op6 == tmx_pkg::OP_DISPLAY_SEGMENT_WRITE) ? tmx_pkg::seg7(m_val) : {3'b000, m_val};
         pll.wr <= ex && ins.op6 == tmx_pkg::OP_PLL;
         pll.sel <= ins.lo;
         pll.data <= m_val;
      end
   end

   // Ports reset to low outputs, port E and F to inputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_b_out <= tmx_pkg::NIB_RST;
         port_c_out <= 2'b00;
         port_h_out <= 2'b00;
         port_e_out <= tmx_pkg::NIB_RST;
         port_f_out <= tmx_pkg::NIB_RST;
         e_dir_q <= 1'b0;
      end else begin
         if (port_we) begin
            unique case (pn)
               tmx_pkg::PORT_B: port_b_out <= port_wd;
               tmx_pkg::PORT_C: port_c_out <= port_wd[1:0];
               tmx_pkg::PORT_E: port_e_out <= port_wd;
               tmx_pkg::PORT_F: port_f_out <= port_wd;
               tmx_pkg::PORT_H: port_h_out <= port_wd[1:0];
               default: ;
            endcase
            if (pn == tmx_pkg::PORT_E) e_dir_q <= 1'b1;
         end else if (ex && pn == tmx_pkg::PORT_E && (ins.op6 == tmx_pkg::OP_IN
               || hi8 == tmx_pkg::OP_TPT || hi8 == tmx_pkg::OP_TPF)) begin
            e_dir_q <= 1'b0;
         end
      end
   end

   // APB slave: no wait states, read data is captured in the setup cycle.
   assign pready = 1'b1;
   assign pslverr = psel && penable && paddr != tmx_pkg::ADDR_CTRL
      && paddr != tmx_pkg::ADDR_STATE && paddr != tmx_pkg::ADDR_STAT1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         if (psel && penable && pwrite && paddr == tmx_pkg::ADDR_CTRL) begin
            run_q <= pwdata[tmx_pkg::CTRL_RUN_BIT];
         end
         if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
               tmx_pkg::ADDR_CTRL: prdata[tmx_pkg::CTRL_RUN_BIT] <= run_q;
               tmx_pkg::ADDR_STATE: prdata <= {13'h0000, skip_q, hold_mode, stopped,
                  4'h0, pc_q};
               tmx_pkg::ADDR_STAT1: prdata <= {28'h0000000, status1};
               default: ;
            endcase
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_jump_target: assert property (ex && ins.op6[5:2] == tmx_pkg::OP_JMP
      |=> pc_q == $past(rom_data[11:0])) else $error("jump target not loaded");
   a_call_return: assert property (ex && ins.op6[5:2] == tmx_pkg::OP_CAL
      ##1 ex && rom_data == tmx_pkg::OP_RT |=> pc_q == $past(pc_q, 2) + 12'h001)
      else $error("return address wrong");
   a_skip_nop: assert property (skip_q |-> !ram_we && !port_we && !push && !pop)
      else $error("skipped instruction acted");
   a_skip_advance: assert property (skip_q && core_q == tmx_pkg::CORE_RUN
      |=> pc_q == $past(pc_q) + 12'h001 && !skip_q) else $error("skip did not advance");
   a_eq_skip: assert property (ex && ins.op6 == tmx_pkg::OP_SEQ
      |=> skip_q == ($past(r_val) == $past(m_val))) else $error("compare skip wrong");
   a_and_write: assert property (ex && ins.op6 == tmx_pkg::OP_AND
      |-> ram_we && ram_wa == m_addr && ram_wd == (m_val & ins.lo)) else $error("and bad");
   a_status_set: assert property (ex && hi12 == tmx_pkg::OP_SS
      |=> status1 == ($past(status1) | $past(ins.lo))) else $error("status set wrong");
   a_stop_hold: assert property (stopped && hold_n |=> !stopped)
      else $error("stopped with hold high");
   a_fdir_load: assert property (ex && hi12 == tmx_pkg::OP_FPC
      |=> port_f_oe == $past(ins.lo)) else $error("port f direction wrong");
   a_porte_out: assert property (port_we && pn == tmx_pkg::PORT_E
      |=> port_e_oe == 4'hf) else $error("port e not output");
   a_nop_quiet: assert property (ex && rom_data == tmx_pkg::OP_NOP
      |-> !ram_we && !port_we && !skip_d && pc_d == pc_q + 12'h001) else $error("nop acted");

   c_call_return: cover property (ex && ins.op6[5:2] == tmx_pkg::OP_CAL ##[1:20]
      ex && rom_data == tmx_pkg::OP_RT);
   c_skip_taken: cover property (ex && skip_d ##1 skip_q);
   c_clock_stop: cover property (core_q == tmx_pkg::CORE_RUN ##1 stopped ##[1:50] !stopped);
endmodule

// file: tmx_rom_model.sv
// Program memory model that answers the executor's fetch address in the same cycle.
module tmx_rom_model (
   input wire logic [11:0] rom_addr,
   output logic [15:0] rom_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [4096];
   // Unused words hold the all-zero opcode, so a stray fetch walks harmlessly.
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
   end
   assign rom_data = mem[rom_addr];
endmodule

// file: tmx_core_tb.sv
// Self-checking bench for the instruction executor and its register port.
module tmx_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_n, timer_flag, unlock_flag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] rom_addr;
   logic [15:0] rom_data;
   logic [3:0] status2, pa, pg, pe, pf, pe_out, pe_oe, pf_out, pf_oe, pb, cw1, cw2, dac, st1;
   logic [1:0] pc_o, ph, bank;
   logic hold_mode, stopped, err;
   tmx_pkg::tmx_lcd_t lcd, lcd_seen;
   tmx_pkg::tmx_pll_t pll, pll_seen;
   int num_errors = 0;
   int comparisons = 0;
   tmx_core i_tmx_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data), .hold_n(hold_n),
      .timer_flag(timer_flag), .unlock_flag(unlock_flag), .status2(status2), .port_a_in(pa),
      .port_g_in(pg), .port_e_in(pe), .port_e_out(pe_out), .port_e_oe(pe_oe), .port_f_in(pf),
      .port_f_out(pf_out), .port_f_oe(pf_oe), .port_b_out(pb), .port_c_out(pc_o),
      .port_h_out(ph), .lcd(lcd), .pll(pll), .counter_control_word_one(cw1),
      .counter_control_word_two(cw2), .dac_data(dac), .status1(st1), .bank(bank),
      .hold_mode(hold_mode), .stopped(stopped));
   tmx_rom_model i_tmx_rom_model (.rom_addr(rom_addr), .rom_data(rom_data));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Pulsed outputs are caught while their strobe stands, as their fields move every cycle.
   always @(posedge pclk) begin
      if (lcd.wr === 1'b1) lcd_seen <= lcd;
      if (pll.wr === 1'b1) pll_seen <= pll;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_idle_regs;
      repeat (4) @(negedge pclk);
      chk("idle pc", 32'h0, {20'h0, rom_addr});
      apb(1'b0, 8'h04, 32'h0);
      chk("state reset", 32'h0, rd);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
   endtask
   // Exercises skips, logic, moves, ports, status, call/return, jump and clock stop.
   task automatic t_program;
      logic [27:0] prog [18];
      prog = '{{12'h000, 16'h9c05}, {12'h001, 16'h1405}, {12'h002, 16'h020a},
         {12'h003, 16'hec01}, {12'h004, 16'hdc03}, {12'h005, 16'hdc42}, {12'h006, 16'h0106},
         {12'h007, 16'h0309}, {12'h008, 16'h1005}, {12'h009, 16'hc100}, {12'h100, 16'h300c},
         {12'h101, 16'hec01}, {12'h102, 16'hd4fd}, {12'h00a, 16'hdf00}, {12'h00b, 16'hb300},
         {12'h00c, 16'hc102}, {12'h00d, 16'hb200}, {12'h200, 16'h1100}};
      foreach (prog[i]) i_tmx_rom_model.mem[prog[i][27:16]] = prog[i][15:0];
      i_tmx_rom_model.mem[12'h201] = 16'hb201;
      apb(1'b1, 8'h00, 32'h1);
      for (int i = 0; i < 300 && stopped !== 1'b1; i++) @(negedge pclk);
      repeat (3) @(negedge pclk);
      chk("stopped", 32'h1, {31'h0, stopped});
      chk("stop pc", 32'h201, {20'h0, rom_addr});
      chk("dac skip", 32'h0, {28'h0, dac});
      chk("port b", 32'h4, {28'h0, pb});
      chk("status1", 32'h1, {28'h0, st1});
      chk("hold mode", 32'h1, {31'h0, hold_mode});
      chk("ucw1", 32'h6, {28'h0, cw1});
      chk("ucw2", 32'h9, {28'h0, cw2});
      chk("port f oe", 32'h5, {28'h0, pf_oe});
   endtask
   task automatic t_resume;
      @(posedge pclk);
      hold_n <= 1'b1;
      repeat (4) @(negedge pclk);
      chk("resumed", 32'h0, {31'h0, stopped});
      chk("resume pc", 32'h201, {20'h0, rom_addr});
      apb(1'b0, 8'h04, 32'h0);
      chk("state pc", 32'h201, {20'h0, rd[11:0]});
      apb(1'b0, 8'h08, 32'h0);
      chk("stat1 reg", 32'h1, rd);
   endtask
   // Display, synthesizer, ports E/F/H, port input, XOR, register compare and bank select.
   task automatic t_program2;
      logic [27:0] prog [17];
      prog = '{{12'h300, 16'h9c19}, {12'h301, 16'he412}, {12'h302, 16'h9813},
         {12'h303, 16'hec13}, {12'h304, 16'hf161}, {12'h305, 16'hec14}, {12'h306, 16'hfa41},
         {12'h307, 16'h020f}, {12'h308, 16'he820}, {12'h309, 16'h2812}, {12'h30a, 16'h0422},
         {12'h30b, 16'hec12}, {12'h30c, 16'hec21}, {12'h30d, 16'he833}, {12'h30e, 16'hd114},
         {12'h30f, 16'h0000}, {12'h310, 16'hb310}};
      @(posedge pclk);
      pa <= 4'h6;
      @(negedge pclk);
      foreach (prog[i]) i_tmx_rom_model.mem[prog[i][27:16]] = prog[i][15:0];
      i_tmx_rom_model.mem[12'h201] = 16'hb300;
      repeat (30) @(negedge pclk);
      chk("loop pc", 32'h310, {20'h0, rom_addr});
      chk("lcd digit", 32'h2, {28'h0, lcd_seen.digit});
      chk("lcd seg", 32'h6f, {25'h0, lcd_seen.seg});
      chk("pll sel", 32'h3, {28'h0, pll_seen.sel});
      chk("pll data", 32'h9, {28'h0, pll_seen.data});
      chk("port e out", 32'h9, {28'h0, pe_out});
      chk("port e oe", 32'h0, {28'h0, pe_oe});
      chk("port h", 32'h1, {30'h0, ph});
      chk("port f out", 32'h9, {28'h0, pf_out});
      chk("dac tpt skip", 32'h0, {28'h0, dac});
      chk("port c seq skip", 32'h0, {30'h0, pc_o});
      chk("port b xor", 32'hf, {28'h0, pb});
      chk("bank", 32'h1, {30'h0, bank});
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {timer_flag, unlock_flag, status2, pa, pg, pe, pf} = '0;
      {lcd_seen, pll_seen} = '0;
      hold_n = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_idle_regs();
      t_program();
      t_resume();
      t_program2();
      tally_and_finish();
   end
endmodule
